/* rtl/isws_top.sv */
// Interrupt action unit: status word swap with an AXI4-Lite register port.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
// ----------------------------------------
// ----------------------------------------
module isws_top
  import isws_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output      logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  input  wire logic              cpu_inst_end,
  input  wire logic [23:0]       cpu_next_addr,
  input  wire logic [1:0]        cpu_instr_length_code,
  input  wire logic              cpu_svc_req,
  input  wire logic [7:0]        cpu_svc_operand,
  input  wire logic              cpu_pgm_req,
  input  wire logic [7:0]        cpu_pgm_code,
  input  wire logic              cpu_pgm_exec,
  input  wire logic              cpu_mchk_req,
  output      logic              cpu_hold,
  output      logic              cpu_suppress,
  output      logic              cpu_terminate,
  output      logic              cpu_resume,
  output      logic [23:0]       cpu_fetch_addr,
  output      logic [63:0]       program_status_doubleword,
  input  wire logic [7:0]        ext_sig,
  input  wire logic              io_req,
  input  wire logic [2:0]        io_chan,
  input  wire logic [7:0]        io_dev,
  output      logic              io_ack,
  output      logic              mem_req,
  output      logic              mem_we,
  output      logic [23:0]       mem_addr,
  output      logic [63:0]       mem_wdata,
  input  wire logic              mem_ack,
  input  wire logic [63:0]       mem_rdata
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // True for an offset that names a register; reads and writes share it.
  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    return (a == REG_CTRL) || (a == REG_STAT) || (a == REG_WHI) ||
           (a == REG_WLO) || (a == REG_CNT);
  endfunction : is_mapped

  // Merges a bus write into a word under its byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // True when the program mask holds back this exception.
  function automatic logic pgm_masked(input logic [7:0] c, input logic [63:0] w);
    return ((c == PC_FXO) && !sw_bit(w, PM_FXO_BIT)) ||
           ((c == PC_DCO) && !sw_bit(w, PM_DCO_BIT)) ||
           ((c == PC_EXU) && !sw_bit(w, PM_EXU_BIT)) ||
           ((c == PC_SIG) && !sw_bit(w, PM_SIG_BIT));
  endfunction : pgm_masked

  isws_regs_t s;
  isws_regs_t n;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------

  // One pass computes the whole next state; pulses fall back to zero.
  always_comb begin
    logic          take;
    logic [15:0]   code;
    logic [63:0]   old;
    logic [31:0]   rd;
    logic [7:0]    ext_live;
    logic          ch_ok;
    logic [31:0]   ctl;
    isws_class_t   cls;
    take     = 1'b0;
    ctl      = 32'h0000_0000;
    code     = 16'h0000;
    old      = s.cur;
    rd       = 32'h0000_0000;
    cls      = CL_NONE;
    ext_live = s.ext_pend & {8{sw_bit(s.cur, MASK_EXT_BIT)}};
    ch_ok    = (io_chan <= 3'(MAX_CHAN)) && sw_bit(s.cur, int'(io_chan));
    n        = s;
    n.io_ack = 1'b0;
    n.sup    = 1'b0;
    n.term   = 1'b0;
    n.resume = 1'b0;
    // New external events land on top of the clear, so none is lost.
    n.ext_pend = s.ext_pend | ext_sig;

    unique case (s.st)
      ST_IDLE: begin
        if (cpu_mchk_req && s.enable && sw_bit(s.cur, MASK_MCHK_BIT)) begin
          take   = 1'b1;
          cls    = CL_MCHK;
          code   = {CODE_ZERO, CODE_ZERO};
          n.term = 1'b1;
        end else if (cpu_pgm_req && !pgm_masked(cpu_pgm_code, s.cur)) begin
          take   = 1'b1;
          cls    = CL_PROG;
          code   = {CODE_ZERO, cpu_pgm_code};
          n.sup  = !cpu_pgm_exec;
          n.term = cpu_pgm_exec;
        end else if (cpu_inst_end) begin
          // Completion-only classes are looked at on a boundary alone.
          if (cpu_svc_req) begin
            take = 1'b1;
            cls  = CL_SVC;
            code = {CODE_ZERO, cpu_svc_operand};
          end else if (s.enable && (ext_live != 8'h00)) begin
            take       = 1'b1;
            cls        = CL_EXT;
            code       = {CODE_ZERO, ext_live};
            n.ext_pend = (s.ext_pend & ~ext_live) | ext_sig;
          end else if (s.enable && io_req && ch_ok) begin
            take     = 1'b1;
            cls      = CL_IO;
            code     = {8'(io_chan), io_dev};
            n.io_ack = 1'b1;
          end
          n.cur[ADDR_LSB +: ADDR_W] = cpu_next_addr;
          n.cur[ILC_LSB +: ILC_W]   = cpu_instr_length_code;
        end
        // The old word carries address, length and code of this event.
        if (take) begin
          old[ADDR_LSB +: ADDR_W] = cpu_next_addr;
          old[ILC_LSB +: ILC_W]   = cpu_instr_length_code;
          old[CODE_LSB +: CODE_W] = code;
          n.cls       = cls;
          n.last_code = code;
          n.mem_wdata = old;
          n.mem_addr  = old_loc(cls);
          n.mem_we    = 1'b1;
          n.mem_req   = 1'b1;
          n.st        = ST_STORE;
        end
      end
      ST_STORE: begin
        // Fetch follows at once so nothing runs between the two moves.
        if (mem_ack) begin
          n.mem_we   = 1'b0;
          n.mem_addr = s.mem_addr + NEW_OFS;
          n.st       = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (mem_ack) begin
          n.cur     = mem_rdata;
          n.mem_req = 1'b0;
          n.resume  = 1'b1;
          n.taken   = s.taken + 32'h0000_0001;
          n.st      = ST_IDLE;
        end
      end
    endcase

    // Write address and data are taken in either order or in the same cycle.
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.waddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = is_mapped(s.waddr) ? RESP_OKAY : RESP_SLVERR;
      if (s.waddr == REG_CTRL) begin
        ctl      = merge({31'h0000_0000, s.enable}, s.wdata, s.wstrb);
        n.enable = ctl[CTRL_EN];
      end
      // The live word is only loaded while no swap is in flight.
      if ((s.waddr == REG_WHI) && (s.st == ST_IDLE)) begin
        n.cur[63:32] = merge(n.cur[63:32], s.wdata, s.wstrb);
      end
      if ((s.waddr == REG_WLO) && (s.st == ST_IDLE)) begin
        n.cur[31:0] = merge(n.cur[31:0], s.wdata, s.wstrb);
      end
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken.
    unique case (s_axi_araddr)
      REG_CTRL: rd[CTRL_EN] = s.enable;
      REG_STAT: begin
        rd[STAT_BUSY]      = (s.st != ST_IDLE);
        rd[STAT_CLS +: 3]  = s.cls;
        rd[STAT_CODE +: 16] = s.last_code;
      end
      REG_WHI:  rd = s.cur[63:32];
      REG_WLO:  rd = s.cur[31:0];
      REG_CNT:  rd = s.taken;
      default:  rd = 32'h0000_0000;
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rdata  = rd;
      n.rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  // Synchronous reset clears every field, the live word included.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Handshake readies are combinational; data leaves from flip-flops.
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready  = !s.w_got && !s.bvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign cpu_hold      = (s.st != ST_IDLE);
  assign cpu_suppress  = s.sup;
  assign cpu_terminate = s.term;
  assign cpu_resume    = s.resume;
  assign cpu_fetch_addr            = s.cur[ADDR_LSB +: ADDR_W];
  assign program_status_doubleword = s.cur;
  assign io_ack    = s.io_ack;
  assign mem_req   = s.mem_req;
  assign mem_we    = s.mem_we;
  assign mem_addr  = s.mem_addr;
  assign mem_wdata = s.mem_wdata;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // The fetched doubleword becomes the live word with a resume pulse.
  a_swap_loads_new: assert property (
    (s.st == ST_FETCH) && mem_ack |=> (s.cur == $past(mem_rdata)) && s.resume)
    else $error("New word not made current.");

  // Each class stores at its own old-word location.
  a_ext_old_loc: assert property (
    (s.st == ST_STORE) && (s.cls == CL_EXT) |-> mem_we && (mem_addr == 24'h00_0018))
    else $error("External old word misplaced.");

  a_svc_old_loc: assert property (
    (s.st == ST_STORE) && (s.cls == CL_SVC) |-> mem_we && (mem_addr == 24'h00_0020))
    else $error("Supervisor call old word misplaced.");

  a_prog_old_loc: assert property (
    (s.st == ST_STORE) && (s.cls == CL_PROG) |-> mem_we && (mem_addr == 24'h00_0028))
    else $error("Program check old word misplaced.");

  a_mchk_old_loc: assert property (
    (s.st == ST_STORE) && (s.cls == CL_MCHK) |-> mem_we && (mem_addr == 24'h00_0030))
    else $error("Machine check old word misplaced.");

  a_io_old_loc: assert property (
    (s.st == ST_STORE) && (s.cls == CL_IO) |-> mem_we && (mem_addr == 24'h00_0038))
    else $error("I/O old word misplaced.");

  // The fetch follows the store at once, 64 bytes higher.
  a_new_above_old: assert property (
    (s.st == ST_STORE) && mem_ack |=> (s.st == ST_FETCH) && mem_req && !mem_we &&
      (mem_addr == $past(mem_addr) + 24'h00_0040) && (mem_addr[2:0] == 3'h0))
    else $error("New word fetch address wrong.");

  // The stored code field matches the code composed for the event.
  a_code_in_old: assert property (
    (s.st == ST_STORE) |-> (mem_wdata[CODE_LSB +: CODE_W] == s.last_code))
    else $error("Interruption code not in stored word.");

  a_mchk_zero: assert property (
    (s.st == ST_STORE) && (s.cls == CL_MCHK) |-> (s.last_code == 16'h0000) && !cpu_suppress)
    else $error("Machine check code not zero.");

  // An accepted channel had its mask bit set in the stored word.
  a_io_masked: assert property (
    (s.st == ST_STORE) && (s.cls == CL_IO) |-> sw_bit(mem_wdata, int'(s.last_code[15:8])))
    else $error("Masked channel accepted.");

  // Program check length code is the one reported at the take.
  a_ilc_set: assert property (
    (s.st == ST_STORE) && ($past(s.st) == ST_IDLE) && (s.cls == CL_PROG) |->
      (mem_wdata[ILC_LSB +: ILC_W] == $past(cpu_instr_length_code)))
    else $error("Length code not stored.");

  // Suppress marks a fetch-time program check, terminate an execution one.
  a_pgm_end_kind: assert property (
    (s.st == ST_STORE) && ($past(s.st) == ST_IDLE) && (s.cls == CL_PROG) |->
      (cpu_suppress == !$past(cpu_pgm_exec)) && (cpu_terminate == $past(cpu_pgm_exec)))
    else $error("Wrong instruction ending on program check.");

endmodule : isws_top

/* rtl/isws_pkg.sv */
// Constants, types and state record for the interrupt status word swap unit.
package isws_pkg;

  // ----------------------------------------
  // Status word layout (field LSBs are vector bit indices; mask bits count bit 0 as the MSB).
  // ----------------------------------------
  localparam int SW_MSB        = 63;
  localparam int CODE_LSB      = 32;
  localparam int CODE_W        = 16;
  localparam int ILC_LSB       = 30;
  localparam int ILC_W         = 2;
  localparam int ADDR_LSB      = 0;
  localparam int ADDR_W        = 24;
  localparam int MASK_EXT_BIT  = 7;
  localparam int MASK_MCHK_BIT = 13;
  localparam int MAX_CHAN      = 6;
  localparam int PM_FXO_BIT    = 36;
  localparam int PM_DCO_BIT    = 37;
  localparam int PM_EXU_BIT    = 38;
  localparam int PM_SIG_BIT    = 39;

  // ----------------------------------------
  // Interruption code values.
  // ----------------------------------------
  localparam logic [7:0] CODE_ZERO = 8'h00;
  localparam logic [7:0] PC_FIRST  = 8'h01;
  localparam logic [7:0] PC_FXO    = 8'h08;
  localparam logic [7:0] PC_DCO    = 8'h0a;
  localparam logic [7:0] PC_EXU    = 8'h0d;
  localparam logic [7:0] PC_SIG    = 8'h0e;
  localparam logic [7:0] PC_LAST   = 8'h0f;

  // ----------------------------------------
  // Fixed old-word locations and new-word offset.
  // ----------------------------------------
  localparam logic [23:0] LOC_EXT_OLD  = 24'h00_0018;
  localparam logic [23:0] LOC_SVC_OLD  = 24'h00_0020;
  localparam logic [23:0] LOC_PROG_OLD = 24'h00_0028;
  localparam logic [23:0] LOC_MCHK_OLD = 24'h00_0030;
  localparam logic [23:0] LOC_IO_OLD   = 24'h00_0038;
  localparam logic [23:0] NEW_OFS      = 24'h00_0040;

  // ----------------------------------------
  // Register map and bus codes.
  // ----------------------------------------
  localparam int         AXI_AW      = 8;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STAT    = 8'h04;
  localparam logic [7:0] REG_WHI     = 8'h08;
  localparam logic [7:0] REG_WLO     = 8'h0c;
  localparam logic [7:0] REG_CNT     = 8'h10;
  localparam int         CTRL_EN     = 0;
  localparam int         STAT_BUSY   = 0;
  localparam int         STAT_CLS    = 1;
  localparam int         STAT_CODE   = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_STORE, ST_FETCH} isws_state_t;
  typedef enum logic [2:0] {CL_NONE, CL_EXT, CL_SVC, CL_PROG, CL_MCHK, CL_IO} isws_class_t;

  typedef struct packed {
    isws_state_t st;
    isws_class_t cls;
    logic [63:0] cur;
    logic        mem_req;
    logic        mem_we;
    logic [23:0] mem_addr;
    logic [63:0] mem_wdata;
    logic [7:0]  ext_pend;
    logic        io_ack;
    logic        sup;
    logic        term;
    logic        resume;
    logic        enable;
    logic [15:0] last_code;
    logic [31:0] taken;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } isws_regs_t;

  // Picks a bit by its status word number, bit 0 being the MSB.
  function automatic logic sw_bit(input logic [63:0] w, input int n);
    return w[SW_MSB - n];
  endfunction : sw_bit

  // Old-word location of each interrupt class.
  function automatic logic [23:0] old_loc(input isws_class_t c);
    unique case (c)
      CL_EXT:  return LOC_EXT_OLD;
      CL_SVC:  return LOC_SVC_OLD;
      CL_PROG: return LOC_PROG_OLD;
      CL_MCHK: return LOC_MCHK_OLD;
      CL_IO:   return LOC_IO_OLD;
      default: return LOC_IO_OLD;
    endcase
  endfunction : old_loc

endpackage : isws_pkg

/* tb/isws_mem.sv */
// Main storage model that answers the swap unit's doubleword requests.
`timescale 1ns/100ps
module isws_mem (
  input  wire logic        aclk,
  input  wire logic [1:0]  lat,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  input  wire logic [63:0] mem_wdata,
  output      logic        mem_ack,
  output      logic [63:0] mem_rdata
);
  logic [63:0] mem [logic [23:0]];
  logic [1:0]  wait_ff;

  initial begin
    mem_ack   = 1'b0;
    mem_rdata = '0;
    wait_ff   = '0;
  end

  // ----------------------------------------
  // Storage access
  // ----------------------------------------
  // Each request is answered after lat idle cycles, so slow storage is tried too.
  // Outside the answer cycle the read bus toggles, so stale data never looks valid.
  always @(posedge aclk) begin
    if (mem_ack || !mem_req) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_ff   <= '0;
    end else if (wait_ff == lat) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 64'h0000_0000_0000_0000;
      if (mem_we) mem[mem_addr] = mem_wdata;
    end else begin
      wait_ff   <= wait_ff + 2'd1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : isws_mem

/* tb/interrupt_status_word_swap_tb.sv */
// Self-checking bench for the interrupt status word swap unit.
`timescale 1ns/100ps
module interrupt_status_word_swap_tb
  import isws_pkg::*;
();
  localparam logic [63:0] MASKW = 64'hff04_0000_0f00_0000;
  logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, cpu_inst_end, cpu_svc_req, cpu_pgm_req;
  logic              cpu_pgm_exec, cpu_mchk_req, io_req, cpu_hold, cpu_suppress;
  logic              cpu_terminate, cpu_resume, io_ack, mem_req, mem_we, mem_ack;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, cpu_instr_length_code, lat;
  logic [23:0]       cpu_next_addr, cpu_fetch_addr, mem_addr;
  logic [7:0]        cpu_svc_operand, cpu_pgm_code, ext_sig, io_dev;
  logic [2:0]        io_chan;
  logic [63:0]       program_status_doubleword, mem_wdata, mem_rdata;
  int                n_errors, comparisons, n_swaps;
  localparam logic [7:0] PM_CODES [4] = '{PC_FXO, PC_DCO, PC_EXU, PC_SIG};
  logic [31:0]       rnd;
  logic [63:0]       cur;
  logic              sup_s, term_s, ack_s;
  logic [88:0]       memq[$];

  isws_top u_isws_top (.*);
  isws_mem u_isws_mem (.*);

  // The clock flips every 12.5 ns, half of its 25 ns period.
  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;

  // Storage transfers and control pulses are logged at the edge that sees them.
  always @(posedge aclk) begin
    if (mem_req && mem_ack) memq.push_back({mem_we, mem_addr, mem_wdata});
    if (cpu_suppress) sup_s = 1'b1;
    if (cpu_terminate) term_s = 1'b1;
    if (io_ack) ack_s = 1'b1;
    if (io_ack) io_req <= 1'b0;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr

  // The new word of class c keeps every mask open and jumps to c times 4096.
  function automatic logic [63:0] newv(input int c);
    return MASKW | 64'(c * 4096);
  endfunction : newv

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p  = 1'b1;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (aw_p && s_axi_awready) aw_p = 1'b0;
      if (w_p && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (w_p && s_axi_wready) w_p = 1'b0;
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // Raises one interrupt of class c with field p and checks the whole swap.
  task automatic irq(input int c, input logic [7:0] p, input logic take);
    logic [23:0] na, ol;
    logic [15:0] code;
    logic [63:0] oldw;
    logic [31:0] d;
    logic [1:0]  r, instr_length_code;
    logic        e, done;
    rnd   = lfsr(rnd);
    na    = rnd[31:8];
    instr_length_code   = (rnd[1:0] == 2'b00) ? 2'b01 : rnd[1:0];
    e     = rnd[2];
    done  = 1'b0;
    sup_s = 1'b0;
    term_s = 1'b0;
    ack_s = 1'b0;
    memq.delete();
    lat <= rnd[4:3];
    if (c == CL_EXT) @(posedge aclk);
    if (c == CL_EXT) ext_sig <= p;
    @(posedge aclk);
    ext_sig               <= 8'h00;
    cpu_next_addr         <= na;
    cpu_instr_length_code <= instr_length_code;
    cpu_inst_end          <= (c == CL_EXT || c == CL_SVC || c == CL_IO);
    cpu_svc_req           <= (c == CL_SVC);
    cpu_svc_operand       <= p;
    cpu_pgm_req           <= (c == CL_PROG);
    cpu_pgm_code          <= p;
    cpu_pgm_exec          <= e;
    cpu_mchk_req          <= (c == CL_MCHK);
    io_req                <= (c == CL_IO);
    io_chan               <= p[2:0];
    io_dev                <= rnd[15:8];
    @(posedge aclk);
    {cpu_inst_end, cpu_svc_req, cpu_pgm_req, cpu_mchk_req} <= 4'h0;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge aclk);
      done = cpu_resume;
    end
    io_req <= 1'b0;
    chk("swap taken", 64'(done), 64'(take));
    chk("hold after", 64'(cpu_hold), 64'd0);
    if (take) begin
      n_swaps++;
      code = (c == CL_IO) ? {5'b0, p[2:0], rnd[15:8]} : (c == CL_MCHK) ? 16'h0000 : {8'h00, p};
      ol   = 24'(24 + 8 * (c - 1));
      oldw = cur;
      oldw[47:32] = code;
      oldw[31:30] = instr_length_code;
      oldw[23:0]  = na;
      chk("transfers", 64'(memq.size()), 64'd2);
      chk("store addr", 64'(memq[0][88:64]), 64'({1'b1, ol}));
      chk("old word", memq[0][63:0], oldw);
      chk("fetch addr", 64'(memq[1][88:64]), 64'(ol + 24'd64));
      chk("suppress", 64'(sup_s), 64'(c == CL_PROG && !e));
      chk("terminate", 64'(term_s), 64'((c == CL_PROG && e) || c == CL_MCHK));
      chk("io taken", 64'(ack_s), 64'(c == CL_IO));
      axi_rd(REG_STAT, d, r);
      chk("last code", 64'(d[31:1]), 64'({code, 12'h000, 3'(c)}));
      chk("live word", program_status_doubleword, newv(c));
      chk("next fetch", 64'(cpu_fetch_addr), 64'(c * 4096));
      cur = newv(c);
    end
  endtask : irq

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  p;
    {aresetn, s_axi_awvalid, s_axi_awaddr, s_axi_wvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_araddr, s_axi_rready, lat} = '0;
    {cpu_inst_end, cpu_next_addr, cpu_instr_length_code, cpu_svc_req, cpu_svc_operand} = '0;
    {cpu_pgm_req, cpu_pgm_code, cpu_pgm_exec, cpu_mchk_req, ext_sig, io_req, io_chan, io_dev} = '0;
    n_errors = 0;
    comparisons = 0;
    n_swaps = 0;
    rnd = 32'h0000_2c5d;
    for (int c = 1; c <= 5; c++) u_isws_mem.mem[24'(88 + 8 * (c - 1))] = newv(c);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(8'h40, d, r);
    chk("unmapped read", 64'(r), 64'(RESP_SLVERR));
    axi_wr(REG_WHI, MASKW[63:32], r);
    axi_wr(REG_WLO, MASKW[31:0], r);
    axi_wr(REG_CTRL, 32'h0000_0001, r);
    chk("write resp", 64'(r), 64'(RESP_OKAY));
    axi_rd(REG_CTRL, d, r);
    chk("enable bit", 64'(d), 64'd1);
    axi_rd(REG_WLO, d, r);
    chk("word low", 64'(d), 64'(MASKW[31:0]));
    cur = MASKW;
    // Every class three times with random fields and storage delays.
    for (int k = 0; k < 15; k++) begin
      rnd = lfsr(rnd);
      p = rnd[7:0];
      if (k % 5 + 1 == CL_PROG) p = 8'(1 + p % 15);
      if (k % 5 + 1 == CL_IO) p = p % 7;
      if (k % 5 + 1 == CL_EXT && p == 8'h00) p = 8'h01;
      irq(k % 5 + 1, p, 1'b1);
    end
    // Closed masks drop the request; the unmaskable program exception still swaps.
    axi_wr(REG_WHI, 32'hff00_0000, r);
    axi_wr(REG_WLO, 32'h0000_0000, r);
    cur = 64'hff00_0000_0000_0000;
    irq(CL_MCHK, 8'h00, 1'b0);
    foreach (PM_CODES[i]) irq(CL_PROG, PM_CODES[i], 1'b0);
    irq(CL_PROG, 8'h09, 1'b1);
    axi_wr(REG_WHI, 32'h1000_0000, r);
    axi_wr(REG_WLO, 32'h0000_0000, r);
    cur = 64'h1000_0000_0000_0000;
    irq(CL_EXT, 8'h01, 1'b0);
    irq(CL_IO, 8'h04, 1'b0);
    irq(CL_IO, 8'h03, 1'b1);
    axi_rd(REG_CNT, d, r);
    chk("swap count", 64'(d), 64'(n_swaps));
    tally_and_finish();
  end

  // Cuts a hang short well past the expected run of about five hundred cycles.
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    tally_and_finish();
  end
endmodule : interrupt_status_word_swap_tb
